// >>> motor_starter_pkg.sv
// Package with mode codes, data bit positions and timing constants
package motor_starter_pkg;

  // Control function selection
  typedef enum logic [1:0] {
    MODE_OVERLOAD = 2'h0,
    MODE_DIRECT = 2'h1,
    MODE_REVERSING = 2'h2
  } ctrl_mode_t;

  // Fault output assignment
  typedef enum logic [1:0] {
    FOUT_NONE = 2'h0,
    FOUT_RELAY2 = 2'h1,
    FOUT_AUX3 = 2'h2
  } fault_out_sel_t;

  // Command byte 0 bit positions
  localparam int CMD_RUN_REV_BIT = 0;
  localparam int CMD_OFF_BIT = 1;
  localparam int CMD_RUN_FWD_BIT = 2;
  localparam int CMD_PREP_EMERG_BIT = 4;
  localparam int CMD_AUTO_BIT = 5;
  localparam int CMD_FAULT_RESET_BIT = 6;
  // Command byte 1 bit positions
  localparam int CMD_AUX_SUPPLY_BIT = 4;
  localparam int CMD_RELAY1_BIT = 6;
  localparam int CMD_RELAY2_BIT = 7;

  // Monitoring byte 0 bit positions
  localparam int MON_RUN_REV_BIT = 0;
  localparam int MON_OFF_BIT = 1;
  localparam int MON_RUN_FWD_BIT = 2;
  localparam int MON_OVERLOAD_WARN_BIT = 3;
  localparam int MON_LOCKOUT_BIT = 4;
  localparam int MON_LOCAL_BIT = 5;
  localparam int MON_FAULT_BIT = 6;
  localparam int MON_WARN_BIT = 7;
  // Monitoring byte 1: inputs start at this bit
  localparam int MON_DI_LSB = 2;

  // Digital input roles
  localparam int DI_CHECKBACK = 0;
  localparam int DI_START_REV = 3;
  localparam int DI_START_FWD = 4;
  localparam int DI_STOP = 5;

  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int CHECKBACK_TIME_US = 100;
  localparam int CHECKBACK_CYCLES = (CHECKBACK_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int LOCKOUT_WIDTH = 32;
  localparam logic [31:0] LOCKOUT_RESET = 32'h0000_0000;

  // Reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;

endpackage : motor_starter_pkg

// >>> dir_if.sv
// Interface carrying direction requests and grants between modules
interface dir_if;
  logic fwd_req; // Forward run requested
  logic rev_req; // Reverse run requested
  logic stop_req; // Stop requested
  logic fwd_on; // Forward contactor energised
  logic rev_on; // Reverse contactor energised
  logic lockout; // Reverse lockout active
  modport ctrl (input fwd_req, input rev_req, input stop_req,
                output fwd_on, output rev_on, output lockout);
  modport user (output fwd_req, output rev_req, output stop_req,
                input fwd_on, input rev_on, input lockout);
endinterface : dir_if

// >>> lockout_timer.sv
// Reverse lockout timer counting after a direction is released
module lockout_timer #(
  parameter int WIDTH = 32 // Counter width
) (
  input wire logic clk_i, // System clock
  input wire logic rst_n_i, // Synchronised reset, active low
  input wire logic start_i, // Pulse: direction output released
  input wire logic [WIDTH-1:0] limit_i, // Lockout length in cycles
  output logic active_o // Lockout still running
);
  logic [WIDTH-1:0] count_reg; // Elapsed cycles
  logic run_reg; // Timer running
  logic done; // Limit reached

  assign done = (count_reg >= limit_i);
  assign active_o = run_reg & ~done;

  // Restart on each release, count until limit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_reg <= '0;
      run_reg <= 1'b0;
    end else if (start_i) begin
      count_reg <= '0;
      run_reg <= 1'b1;
    end else if (run_reg && !done) begin
      count_reg <= count_reg + 1'b1;
    end else begin
      run_reg <= 1'b0;
    end
  end
endmodule // lockout_timer

// >>> direction_ctrl.sv
// Run direction state machine with interlock and lockout
module direction_ctrl #(
  parameter int WIDTH = 32 // Lockout counter width
) (
  input wire logic clk_i, // System clock
  input wire logic rst_n_i, // Synchronised reset, active low
  input wire logic reversing_i, // Reversing allowed
  input wire logic [WIDTH-1:0] lockout_cycles_i, // Lockout length
  dir_if.ctrl dir // Requests and contactor states
);
  typedef enum logic [1:0] {ST_OFF, ST_FWD, ST_REV} run_state_t;
  run_state_t state_reg; // Current direction
  run_state_t state_next; // Next direction
  logic last_rev_reg; // Previous run was reverse
  logic released; // A direction output drops at the next edge
  logic lock_act; // Lockout running

  lockout_timer #(.WIDTH(WIDTH)) u_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(released),
    .limit_i(lockout_cycles_i),
    .active_o(lock_act)
  );

  // Timer starts when running output is released
  assign released = (state_reg != ST_OFF) && (state_next == ST_OFF);

  // Next state: stop wins, opposite direction only after off + lockout
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (dir.stop_req) begin
          state_next = ST_OFF;
        end else if (dir.fwd_req && !dir.rev_req &&
                     (!last_rev_reg || !lock_act)) begin
          state_next = ST_FWD;
        end else if (reversing_i && dir.rev_req && !dir.fwd_req &&
                     (last_rev_reg || !lock_act)) begin
          state_next = ST_REV;
        end
      end
      ST_FWD: begin
        if (dir.stop_req) state_next = ST_OFF;
      end
      ST_REV: begin
        if (dir.stop_req || !reversing_i) state_next = ST_OFF;
      end
      default: state_next = ST_OFF;
    endcase
  end

  // State and last direction registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_OFF;
      last_rev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_FWD) last_rev_reg <= 1'b0;
      if (state_reg == ST_REV) last_rev_reg <= 1'b1;
    end
  end

  // Exclusive outputs by construction
  assign dir.fwd_on = (state_reg == ST_FWD);
  assign dir.rev_on = (state_reg == ST_REV);
  assign dir.lockout = lock_act;

  never_both_a: assert property (@(posedge clk_i)
    disable iff (!rst_n_i) !(dir.fwd_on && dir.rev_on))
    else $error("both directions on");

  // Reverse drop with a non-zero lockout; a zero lockout lets forward
  // follow one cycle sooner and is legal
  sequence rev_to_off_s;
    dir.rev_on && (lockout_cycles_i != '0) ##1 !dir.rev_on;
  endsequence
  no_quick_fwd_a: assert property (@(posedge clk_i)
    disable iff (!rst_n_i) rev_to_off_s |-> !dir.fwd_on [*2])
    else $error("reversed too fast");

  stop_wins_a: assert property (@(posedge clk_i)
    disable iff (!rst_n_i) dir.stop_req |=> !dir.fwd_on && !dir.rev_on)
    else $error("stop not obeyed");

  lock_starts_a: assert property (@(posedge clk_i)
    disable iff (!rst_n_i) released && lockout_cycles_i > 1 |=> dir.lockout)
    else $error("lockout not started");
endmodule // direction_ctrl

// >>> motor_starter_control.sv
// Top: motor starter control mapping command bits to relays and status
// Operation
// - Overload mode reports warning, fault, inputs
// - Command bits drive fault reset, relay2, aux
// - Fault output overrides its command bit
// - Direct mode drives main contactor on relay0
// - Optional checkback on input 0 supervised
// - Direct mode local start input4, stop input5
// - Optional fault output relay2 or aux3
// - Direct mode reports local, run, off bits
// - Direct commands auto, run, off; relay1 direct
// - Reversing: relay0 forward, relay1 reverse, exclusive
// - Reversing local starts inputs 3/4, stop 5
// - Opposite direction only after off plus lockout
// - Same direction restart without lockout wait
// - Overload mode: relay0 closed, fault swaps relays
// - Reversing run reverse bit0, lockout bit4
module motor_starter_control
  import motor_starter_pkg::*;
#(
  parameter int LOCKOUT_WIDTH_P = motor_starter_pkg::LOCKOUT_WIDTH, // Width
  parameter int CHECKBACK_CYCLES_P = motor_starter_pkg::CHECKBACK_CYCLES
) (
  input wire logic clk_i, // 250 MHz clock
  input wire logic arst_n_i, // Async reset, active low
  input wire motor_starter_pkg::ctrl_mode_t mode_i, // Control function
  input wire motor_starter_pkg::fault_out_sel_t fault_sel_i, // Fault out
  input wire logic checkback_en_i, // Use input 0 as checkback
  input wire logic local_en_i, // Allow local start/stop inputs
  input wire logic [LOCKOUT_WIDTH_P-1:0] lockout_cycles_i, // Lockout
  input wire logic ext_fault_i, // Fault from protection logic
  input wire logic warning_i, // Summary warning
  input wire logic overload_warn_i, // Overload warning
  input wire logic [7:0] cmd_byte0_i, // Fieldbus command byte 0
  input wire logic [7:0] cmd_byte1_i, // Fieldbus command byte 1
  input wire logic [5:0] dig_in_i, // Digital inputs 5..0
  output logic [7:0] mon_byte0_o, // Monitoring byte 0
  output logic [7:0] mon_byte1_o, // Monitoring byte 1
  output logic relay_out_0_o, // Relay output 0
  output logic relay_out_1_o, // Relay output 1
  output logic relay_out_2_o, // Relay output 2
  output logic aux_out_3_o, // Aux 24 V output 3
  output logic fault_o, // Fault state
  output logic prep_emerg_o // Prepare emergency start, from command
);
  import motor_starter_pkg::*;

  logic rst_sync1_reg; // Reset synchroniser stage 1
  logic rst_n; // Synchronised reset
  logic cb_fault_reg; // Checkback fault latched
  logic [31:0] cb_cnt_reg; // Checkback mismatch counter
  logic fault; // Combined fault
  logic starter; // Direct or reversing mode
  logic local_ctl; // Local control active
  logic loc_fwd; // Local forward start
  logic loc_rev; // Local reverse start
  logic loc_stop; // Local stop
  logic contactor_cmd; // Any contactor commanded
  logic cb_mismatch; // Checkback disagrees
  logic r0_next; // Relay 0 next
  logic r1_next; // Relay 1 next
  logic r2_next; // Relay 2 next
  logic a3_next; // Aux 3 next
  logic [7:0] mon0_next; // Monitoring byte 0 next
  logic [7:0] mon1_next; // Monitoring byte 1 next
  dir_if dir (); // Direction requests

  // Reset release through two flip-flops
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_n <= rst_sync1_reg;
    end
  end

  // Mode decoding and local station inputs
  assign starter = (mode_i == MODE_DIRECT) || (mode_i == MODE_REVERSING);
  assign local_ctl = starter && local_en_i &&
                     !cmd_byte0_i[CMD_AUTO_BIT];
  assign loc_fwd = local_ctl && dig_in_i[DI_START_FWD];
  assign loc_rev = local_ctl && (mode_i == MODE_REVERSING) &&
                   dig_in_i[DI_START_REV];
  assign loc_stop = starter && local_en_i && dig_in_i[DI_STOP];
  assign fault = ext_fault_i || cb_fault_reg;

  // Requests: off or fault stops; bus used in auto mode
  assign dir.stop_req = !starter || fault || loc_stop ||
                        cmd_byte0_i[CMD_OFF_BIT];
  assign dir.fwd_req = loc_fwd || (!local_ctl &&
                       cmd_byte0_i[CMD_RUN_FWD_BIT]);
  assign dir.rev_req = loc_rev || (!local_ctl &&
                       (mode_i == MODE_REVERSING) &&
                       cmd_byte0_i[CMD_RUN_REV_BIT]);

  direction_ctrl #(.WIDTH(LOCKOUT_WIDTH_P)) u_dir (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .reversing_i(mode_i == MODE_REVERSING),
    .lockout_cycles_i(lockout_cycles_i),
    .dir(dir)
  );

  // Checkback compares input 0 to commanded contactor state
  assign contactor_cmd = dir.fwd_on || dir.rev_on;
  assign cb_mismatch = starter && checkback_en_i &&
                       (dig_in_i[DI_CHECKBACK] != contactor_cmd);

  // Mismatch must persist before a fault; reset clears unless set again
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cb_cnt_reg <= 32'h0000_0000;
      cb_fault_reg <= 1'b0;
    end else begin
      cb_cnt_reg <= cb_mismatch ? cb_cnt_reg + 32'h0000_0001
                                : 32'h0000_0000;
      if (cb_mismatch && cb_cnt_reg >= 32'(CHECKBACK_CYCLES_P))
        cb_fault_reg <= 1'b1;
      else if (cmd_byte0_i[CMD_FAULT_RESET_BIT])
        cb_fault_reg <= 1'b0;
    end
  end

  // Relay 0 and 1 selection by mode
  assign r0_next = (mode_i == MODE_OVERLOAD) ? !fault :
                   dir.fwd_on;
  assign r1_next = (mode_i == MODE_OVERLOAD) ? fault :
                   (mode_i == MODE_DIRECT) ?
                   cmd_byte1_i[CMD_RELAY1_BIT] :
                   dir.rev_on;
  // Fault output overrides the bus bit
  assign r2_next = (fault_sel_i == FOUT_RELAY2) ? fault :
                   cmd_byte1_i[CMD_RELAY2_BIT];
  assign a3_next = (fault_sel_i == FOUT_AUX3) ? fault :
                   cmd_byte1_i[CMD_AUX_SUPPLY_BIT];

  // Monitoring byte 0 packing
  always_comb begin
    mon0_next = BYTE_RESET;
    mon0_next[MON_WARN_BIT] = warning_i;
    mon0_next[MON_FAULT_BIT] = fault;
    mon0_next[MON_OVERLOAD_WARN_BIT] = overload_warn_i;
    if (starter) begin
      mon0_next[MON_LOCAL_BIT] = local_ctl;
      mon0_next[MON_RUN_FWD_BIT] = dir.fwd_on;
      mon0_next[MON_OFF_BIT] = !contactor_cmd;
    end
    if (mode_i == MODE_REVERSING) begin
      mon0_next[MON_RUN_REV_BIT] = dir.rev_on;
      mon0_next[MON_LOCKOUT_BIT] = dir.lockout;
    end
  end
  assign mon1_next = {dig_in_i, 2'b00};

  // Output registers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      relay_out_0_o <= 1'b0;
      relay_out_1_o <= 1'b0;
      relay_out_2_o <= 1'b0;
      aux_out_3_o <= 1'b0;
      mon_byte0_o <= BYTE_RESET;
      mon_byte1_o <= BYTE_RESET;
      fault_o <= 1'b0;
      prep_emerg_o <= 1'b0;
    end else begin
      relay_out_0_o <= r0_next;
      relay_out_1_o <= r1_next;
      relay_out_2_o <= r2_next;
      aux_out_3_o <= a3_next;
      mon_byte0_o <= mon0_next;
      mon_byte1_o <= mon1_next;
      fault_o <= fault;
      prep_emerg_o <= cmd_byte0_i[CMD_PREP_EMERG_BIT];
    end
  end

  // Sampled rst_n in the antecedents skips the edge at which the reset
  // copy rises: the output registers still load reset values there
  ovl_relays_a: assert property (@(posedge clk_i)
    disable iff (!rst_n) rst_n && mode_i == MODE_OVERLOAD
    |=> relay_out_0_o == !$past(fault))
    else $error("overload relay 0 wrong");

  fault_out_a: assert property (@(posedge clk_i)
    disable iff (!rst_n) rst_n && fault_sel_i == FOUT_AUX3
    |=> aux_out_3_o == $past(fault))
    else $error("aux fault output wrong");

  relay2_fault_a: assert property (@(posedge clk_i)
    disable iff (!rst_n) rst_n && fault_sel_i == FOUT_RELAY2
    |=> relay_out_2_o == $past(fault))
    else $error("relay 2 fault output wrong");

  direct_relay1_a: assert property (@(posedge clk_i)
    disable iff (!rst_n) rst_n && mode_i == MODE_DIRECT
    |=> relay_out_1_o == $past(cmd_byte1_i[CMD_RELAY1_BIT]))
    else $error("direct relay 1 wrong");

  inputs_mon_a: assert property (@(posedge clk_i)
    disable iff (!rst_n) rst_n |=> mon_byte1_o[7:2] == $past(dig_in_i))
    else $error("input levels wrong");

  dir_relay_a: assert property (@(posedge clk_i)
    disable iff (!rst_n)
    mode_i == MODE_REVERSING ##1 mode_i == MODE_REVERSING
    |-> !(relay_out_0_o && relay_out_1_o))
    else $error("relay interlock broken");
endmodule // motor_starter_control

// >>> fieldbus_ctrl_model.sv
// Fieldbus controller model that packs named command bits into two bytes
module fieldbus_ctrl_model
  import motor_starter_pkg::*;
(
  input wire logic clk_i, // System clock
  output logic [7:0] cmd_byte0_o, // Command byte 0
  output logic [7:0] cmd_byte1_o // Command byte 1
);
  timeunit 1ns;
  timeprecision 1ps;
  // Unused command bits stay low
  initial begin
    cmd_byte0_o = 8'h00;
    cmd_byte1_o = 8'h00;
  end
  // Run request bits, changed on the falling edge
  task automatic set_run(input logic au, fw, of, rv);
    @(negedge clk_i);
    cmd_byte0_o[CMD_AUTO_BIT] = au;
    cmd_byte0_o[CMD_RUN_FWD_BIT] = fw;
    cmd_byte0_o[CMD_OFF_BIT] = of;
    cmd_byte0_o[CMD_RUN_REV_BIT] = rv;
  endtask
  // Fault reset, emergency prepare and direct output bits
  task automatic set_misc(input logic fr, pe, o1, o2, ax);
    @(negedge clk_i);
    cmd_byte0_o[CMD_FAULT_RESET_BIT] = fr;
    cmd_byte0_o[CMD_PREP_EMERG_BIT] = pe;
    cmd_byte1_o[CMD_RELAY1_BIT] = o1;
    cmd_byte1_o[CMD_RELAY2_BIT] = o2;
    cmd_byte1_o[CMD_AUX_SUPPLY_BIT] = ax;
  endtask
endmodule // fieldbus_ctrl_model

// >>> tb_motor_starter_control.sv
// Self-checking bench for the motor starter control block
module tb_motor_starter_control;
  timeunit 1ns;
  timeprecision 1ps;
  import motor_starter_pkg::*;
  localparam int LOCK = 20; // Short lockout for simulation
  logic clk, arst_n, cb_en, loc_en, ext_f, warn, ovl; // Stimulus
  ctrl_mode_t mode; // Control function
  fault_out_sel_t fsel; // Fault output choice
  logic [5:0] din; // Digital inputs
  logic [7:0] cmd0, cmd1, mon0, mon1; // Command and status bytes
  logic r0, r1, r2, r3, fo, pe; // Outputs
  logic [31:0] lock_cyc = LOCK; // Lockout length
  logic [31:0] v; // Random word
  integer seed = 48; // Fixed seed
  integer err_total = 0; // Mismatches
  integer n_checks = 0; // Comparisons
  // Clock at 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  fieldbus_ctrl_model plc_inst (.clk_i(clk), .cmd_byte0_o(cmd0),
    .cmd_byte1_o(cmd1));
  motor_starter_control #(.CHECKBACK_CYCLES_P(4)) motor_starter_control_inst (
    .clk_i(clk), .arst_n_i(arst_n), .mode_i(mode), .fault_sel_i(fsel),
    .checkback_en_i(cb_en), .local_en_i(loc_en), .lockout_cycles_i(lock_cyc),
    .ext_fault_i(ext_f), .warning_i(warn), .overload_warn_i(ovl),
    .cmd_byte0_i(cmd0), .cmd_byte1_i(cmd1), .dig_in_i(din),
    .mon_byte0_o(mon0), .mon_byte1_o(mon1), .relay_out_0_o(r0),
    .relay_out_1_o(r1), .relay_out_2_o(r2), .aux_out_3_o(r3),
    .fault_o(fo), .prep_emerg_o(pe));
  // Compare one value and count
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Let a number of falling edges pass
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Fault output pin: own fault state or the command bit
  function automatic logic fo_pin(input logic own, f, c);
    return own ? f : c;
  endfunction
  // Verdict and end of run
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Cut a hang short
  initial begin
    #20000;
    err_total++;
    finish_test;
  end
  // Main sequence
  initial begin
    arst_n = 1'b0;
    mode = MODE_OVERLOAD;
    fsel = FOUT_NONE;
    cb_en = 1'b0;
    loc_en = 1'b0;
    ext_f = 1'b0;
    warn = 1'b0;
    ovl = 1'b0;
    din = 6'h00;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    wt(4);
    chk("ovl_r0", r0, 1'b1);
    chk("ovl_r1", r1, 1'b0);
    // Overload mode with random inputs
    for (int i = 0; i < 24; i++) begin
      v = $random(seed);
      plc_inst.set_misc(1'b0, v[0], v[1], v[2], v[3]);
      ext_f = v[4];
      warn = v[5];
      ovl = v[6];
      din = v[12:7];
      fsel = fault_out_sel_t'(v[14:13] % 2'h3);
      wt(3);
      chk("mon0", mon0, {warn, ext_f, 2'h0, ovl, 3'h0});
      chk("mon1", mon1, {din, 2'h0});
      chk("r0", r0, !ext_f);
      chk("r1", r1, ext_f);
      chk("r2", r2, fo_pin(fsel == FOUT_RELAY2, ext_f, v[2]));
      chk("aux", r3, fo_pin(fsel == FOUT_AUX3, ext_f, v[3]));
      chk("prep", pe, v[0]);
    end
    $display("test overload done");
    // Direct starter: run, direct relay, off priority, fault
    mode = MODE_DIRECT;
    fsel = FOUT_RELAY2;
    ext_f = 1'b0;
    din = 6'h00;
    plc_inst.set_misc(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    plc_inst.set_run(1'b1, 1'b1, 1'b0, 1'b0);
    wt(4);
    chk("dir_run", r0, 1'b1);
    chk("dir_mon", mon0 & 8'h26, 8'h04);
    chk("dir_r1", r1, 1'b1);
    plc_inst.set_run(1'b1, 1'b1, 1'b1, 1'b0);
    wt(4);
    chk("off_pri", r0, 1'b0);
    chk("off_mon", mon0 & 8'h06, 8'h02);
    plc_inst.set_run(1'b1, 1'b1, 1'b0, 1'b0);
    wt(4);
    ext_f = 1'b1;
    wt(4);
    chk("flt_r0", r0, 1'b0);
    chk("flt_out", r2, 1'b1);
    plc_inst.set_run(1'b1, 1'b0, 1'b0, 1'b0);
    ext_f = 1'b0;
    // Local start and stop inputs
    loc_en = 1'b1;
    plc_inst.set_run(1'b0, 1'b0, 1'b0, 1'b0);
    din = 6'h10;
    wt(4);
    chk("loc_run", r0, 1'b1);
    chk("loc_mon", mon0[MON_LOCAL_BIT], 1'b1);
    din = 6'h20;
    wt(4);
    chk("loc_stop", r0, 1'b0);
    din = 6'h00;
    loc_en = 1'b0;
    // Missing checkback raises a fault, fault reset clears it
    cb_en = 1'b1;
    plc_inst.set_run(1'b1, 1'b1, 1'b0, 1'b0);
    wt(20);
    chk("cb_flt", fo, 1'b1);
    chk("cb_r0", r0, 1'b0);
    plc_inst.set_run(1'b1, 1'b0, 1'b0, 1'b0);
    plc_inst.set_misc(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    wt(3);
    plc_inst.set_misc(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    wt(3);
    chk("cb_clr", fo, 1'b0);
    cb_en = 1'b0;
    $display("test direct done");
    // Reversing: lockout rejects opposite, same direction restarts
    mode = MODE_REVERSING;
    plc_inst.set_run(1'b1, 1'b1, 1'b0, 1'b0);
    wt(4);
    chk("rev_fwd", r0, 1'b1);
    plc_inst.set_run(1'b1, 1'b0, 1'b1, 1'b0);
    wt(3);
    chk("lk_on", mon0[MON_LOCKOUT_BIT], 1'b1);
    plc_inst.set_run(1'b1, 1'b0, 1'b0, 1'b1);
    wt(3);
    chk("lk_rej", r1, 1'b0);
    plc_inst.set_run(1'b1, 1'b1, 1'b0, 1'b0);
    wt(4);
    chk("same_dir", r0, 1'b1);
    plc_inst.set_run(1'b1, 1'b0, 1'b1, 1'b0);
    wt(LOCK + 10);
    chk("lk_off", mon0[MON_LOCKOUT_BIT], 1'b0);
    plc_inst.set_run(1'b1, 1'b0, 1'b0, 1'b1);
    wt(4);
    chk("rev_run", r1, 1'b1);
    chk("rev_mon", mon0 & 8'h17, 8'h01);
    plc_inst.set_run(1'b0, 1'b0, 1'b1, 1'b0);
    wt(LOCK + 10);
    loc_en = 1'b1;
    plc_inst.set_run(1'b0, 1'b0, 1'b0, 1'b0);
    din = 6'h08;
    wt(4);
    chk("loc_rev", r1, 1'b1);
    din = 6'h20;
    wt(4);
    chk("loc_rstp", r1, 1'b0);
    $display("test reversing done");
    finish_test;
  end
endmodule // tb_motor_starter_control
